//--- shared/ee_loader_pkg.sv
// Constants, field layout and carrier types of the serial EEPROM setup loader.
// Assumes a 40 MHz system clock and a three-wire 64x16 serial EEPROM.
package ee_loader_pkg;
   localparam int CLK_NS = 25;
   localparam int SK_HALF_NS = 500;
   localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_TIMEOUT_NS = 10000000;
   localparam int WR_TIMEOUT_CYC = WR_TIMEOUT_NS / CLK_NS;
   localparam int BOOT_SETTLE_CYC = 3;
   localparam int BUSY_IGNORE_CYC = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PTR = 8'h04;
   localparam logic [7:0] OFS_GP = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0c;
   localparam logic [7:0] OFS_BASE = 8'h10;
   localparam logic [7:0] OFS_SA0 = 8'h14;
   localparam logic [7:0] OFS_SA1 = 8'h18;
   localparam logic [7:0] OFS_SA2 = 8'h1c;

   // Control register fields
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_FETCH_BIT = 1;
   localparam int CTRL_STORE_BIT = 2;

   // Reset values
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] BASE_RST = 16'h0000;
   localparam logic [47:0] SA_RST = 48'h0000_0000_0000;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [15:0] GP_RST = 16'h0000;

   // EEPROM geometry and map
   localparam int EE_AW = 6;
   localparam int EE_DW = 16;
   localparam logic [2:0] SLOT_DEFAULT = 3'h7;
   localparam logic [5:0] EE_SA_ADDR = 6'h20;

   // Serial opcodes
   localparam logic [1:0] OP_EWEN = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [5:0] EWEN_ADDR = 6'h30;
   localparam logic [4:0] LAST_BIT_FULL = 5'h18;
   localparam logic [4:0] LAST_BIT_SHORT = 5'h08;
   localparam logic [4:0] FIRST_DATA_BIT = 5'h09;

   typedef struct packed {
      logic [1:0] op;
      logic [EE_AW-1:0] addr;
      logic [EE_DW-1:0] wdata;
      logic wait_rdy;
   } ee_req_t;

   typedef enum logic [2:0] {
      DST_NONE = 3'h0,
      DST_CFG = 3'h1,
      DST_BASE = 3'h2,
      DST_SA0 = 3'h3,
      DST_SA1 = 3'h4,
      DST_SA2 = 3'h5,
      DST_GP = 3'h6
   } ee_dest_t;
endpackage : ee_loader_pkg

//--- hw/ee_word_xfer.sv
// One three-wire serial EEPROM word transfer: start, opcode, address, data.
// Assumes the EEPROM data-out pin is asynchronous; it is synchronised here.
`timescale 1ns/1ps
module ee_word_xfer #(
   parameter int WR_TIMEOUT_CYC = ee_loader_pkg::WR_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire ee_loader_pkg::ee_req_t req_i,
   input wire logic eeprom_do_i,
   output logic eeprom_cs_o,
   output logic eeprom_sk_o,
   output logic eeprom_di_o,
   output logic [15:0] rdata_o,
   output logic done_o
);
   localparam int WW = $clog2(WR_TIMEOUT_CYC + 1);
   localparam logic [7:0] HALF_LAST = 8'(ee_loader_pkg::SK_HALF_CYC - 1);
   localparam logic [WW-1:0] WAIT_LAST = WW'(WR_TIMEOUT_CYC - 1);
   localparam logic [WW-1:0] WAIT_IGN = WW'(ee_loader_pkg::BUSY_IGNORE_CYC);

   typedef enum logic [3:0] {
      X_IDLE = 4'h1,
      X_SHIFT = 4'h2,
      X_GAP = 4'h4,
      X_BUSY = 4'h8
   } xfer_state_t;

   xfer_state_t state_r;
   ee_loader_pkg::ee_req_t req_r;
   logic do_s1_r;
   logic do_s2_r;
   logic [7:0] tick_r;
   logic [4:0] bit_r;
   logic [24:0] sh_r;
   logic [WW-1:0] wait_r;
   logic half_done;
   logic [4:0] last_bit;

   // Data-out synchroniser
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         do_s1_r <= 1'b0;
         do_s2_r <= 1'b0;
      end
      else
      begin
         do_s1_r <= eeprom_do_i;
         do_s2_r <= do_s1_r;
      end
   end

   assign half_done = (tick_r == HALF_LAST);
   assign last_bit = (req_r.op == ee_loader_pkg::OP_EWEN) ?
                     ee_loader_pkg::LAST_BIT_SHORT : ee_loader_pkg::LAST_BIT_FULL;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= X_IDLE;
         req_r <= '0;
         tick_r <= 8'h00;
         bit_r <= 5'h00;
         sh_r <= 25'h0000000;
         wait_r <= '0;
         eeprom_cs_o <= 1'b0;
         eeprom_sk_o <= 1'b0;
         eeprom_di_o <= 1'b0;
         rdata_o <= 16'h0000;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         case (state_r)
            X_IDLE:
            begin
               if (start_i)
               begin
                  req_r <= req_i;
                  sh_r <= {1'b1, req_i.op, req_i.addr, req_i.wdata};
                  eeprom_cs_o <= 1'b1;
                  eeprom_di_o <= 1'b1;
                  eeprom_sk_o <= 1'b0;
                  tick_r <= 8'h00;
                  bit_r <= 5'h00;
                  state_r <= X_SHIFT;
               end
            end
            X_SHIFT:
            begin
               if (!half_done)
                  tick_r <= tick_r + 8'h01;
               else
               begin
                  tick_r <= 8'h00;
                  if (!eeprom_sk_o)
                     eeprom_sk_o <= 1'b1;
                  else
                  begin
                     eeprom_sk_o <= 1'b0;
                     if (req_r.op == ee_loader_pkg::OP_READ &&
                         bit_r >= ee_loader_pkg::FIRST_DATA_BIT)
                        rdata_o <= {rdata_o[14:0], do_s2_r};
                     if (bit_r == last_bit)
                     begin
                        eeprom_cs_o <= 1'b0;
                        eeprom_di_o <= 1'b0;
                        state_r <= X_GAP;
                     end
                     else
                     begin
                        bit_r <= bit_r + 5'h01;
                        sh_r <= {sh_r[23:0], 1'b0};
                        eeprom_di_o <= sh_r[23];
                     end
                  end
               end
            end
            X_GAP:
            begin
               if (!half_done)
                  tick_r <= tick_r + 8'h01;
               else
               begin
                  tick_r <= 8'h00;
                  wait_r <= '0;
                  if (req_r.wait_rdy)
                  begin
                     eeprom_cs_o <= 1'b1;
                     state_r <= X_BUSY;
                  end
                  else
                  begin
                     done_o <= 1'b1;
                     state_r <= X_IDLE;
                  end
               end
            end
            X_BUSY:
            begin
               wait_r <= wait_r + 1'b1;
               if ((wait_r >= WAIT_IGN && do_s2_r) || wait_r == WAIT_LAST)
               begin
                  eeprom_cs_o <= 1'b0;
                  done_o <= 1'b1;
                  state_r <= X_IDLE;
               end
            end
            default:
               state_r <= X_IDLE;
         endcase
      end
   end
endmodule : ee_word_xfer

//--- hw/serial_eeprom_setup_loader.sv
// Setup loader: fetches and stores board setup words in a 64x16 serial EEPROM,
// with a classic Wishbone register slave for software.
// Assumes strap and EEPROM pins are asynchronous to clk_i.
// Behaviour
// - After reset, setup words are fetched from the EEPROM automatically.
// - Configuration word sits at slot select times four, base word at next address.
// - Station address always comes from EEPROM words 20h to 22h.
// - Slot select 7 fetches station address only; others keep their present values.
// - EEPROM is 64 words of 16 bits, accessed by whole words only.
// - Target 0 fetch loads configuration, base and station address registers.
// - Target 0 store writes configuration and base words to slot locations.
// - Control bits 0..2 are target, fetch and store; never kept in EEPROM.
// - Target 1 fetch reads the pointer-addressed word into general purpose.
// - Target 1 store writes general purpose into the pointer-addressed word.
// - Software sets a request bit and polls; hardware clears it on completion.
// - While busy, both request bits read back as one.
// - While busy, no other register can be read or written.
// - With the present pin low when sampled after reset, the EEPROM is never touched.
`timescale 1ns/1ps
module serial_eeprom_setup_loader #(
   parameter logic [15:0] CFG_DEFAULT = ee_loader_pkg::CFG_RST,
   parameter logic [15:0] BASE_DEFAULT = ee_loader_pkg::BASE_RST,
   parameter logic [47:0] SA_DEFAULT = ee_loader_pkg::SA_RST,
   parameter int WR_TIMEOUT_CYC = ee_loader_pkg::WR_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [2:0] board_slot_select_pins_i,
   input wire logic eeprom_present_pin_i,
   input wire logic eeprom_do_i,
   output logic eeprom_cs_o,
   output logic eeprom_sk_o,
   output logic eeprom_di_o,
   output logic [15:0] cfg_word_o,
   output logic [15:0] base_word_o,
   output logic [47:0] station_addr_words_o
);
   typedef enum logic [3:0] {
      M_BOOT = 4'h1,
      M_IDLE = 4'h2,
      M_ISSUE = 4'h4,
      M_WAIT = 4'h8
   } main_state_t;

   main_state_t state_r;
   logic [2:0] slot_s1_r;
   logic [2:0] slot_s2_r;
   logic pres_s1_r;
   logic pres_s2_r;
   logic present_r;
   logic [2:0] slot_r;
   logic [1:0] boot_cnt_r;
   logic tgt_r;
   logic store_r;
   logic [2:0] step_r;
   logic start_r;
   logic [15:0] ptr_r;
   logic [15:0] gp_r;
   logic [15:0] sa0_r;
   logic [15:0] sa1_r;
   logic [15:0] sa2_r;
   logic [31:0] rd_mux;
   logic busy;
   logic acc;
   logic wr_go;
   logic ctrl_wr;
   logic [15:0] xfer_rdata;
   logic xfer_done;
   ee_loader_pkg::ee_req_t plan_req;
   ee_loader_pkg::ee_dest_t plan_dest;
   logic plan_last;
   logic [5:0] slot_addr;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   assign busy = (state_r != M_IDLE);
   assign acc = cyc_i & stb_i;
   assign wr_go = acc & we_i & ack_o;
   assign ctrl_wr = wr_go && adr_i == ee_loader_pkg::OFS_CTRL && sel_i[0];
   assign slot_addr = {1'b0, slot_r, 2'h0};

   // Strap and slot pin synchronisers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         slot_s1_r <= 3'h0;
         slot_s2_r <= 3'h0;
         pres_s1_r <= 1'b0;
         pres_s2_r <= 1'b0;
      end
      else
      begin
         slot_s1_r <= board_slot_select_pins_i;
         slot_s2_r <= slot_s1_r;
         pres_s1_r <= eeprom_present_pin_i;
         pres_s2_r <= pres_s1_r;
      end
   end

   // Word sequence for the current operation
   always_comb
   begin
      plan_req = '0;
      plan_dest = ee_loader_pkg::DST_NONE;
      plan_last = 1'b0;
      if (!store_r && !tgt_r)
      begin
         plan_req.op = ee_loader_pkg::OP_READ;
         case (step_r)
            3'h0:
            begin
               plan_req.addr = slot_addr;
               plan_dest = ee_loader_pkg::DST_CFG;
            end
            3'h1:
            begin
               plan_req.addr = slot_addr + 6'h01;
               plan_dest = ee_loader_pkg::DST_BASE;
            end
            3'h2:
            begin
               plan_req.addr = ee_loader_pkg::EE_SA_ADDR;
               plan_dest = ee_loader_pkg::DST_SA0;
            end
            3'h3:
            begin
               plan_req.addr = ee_loader_pkg::EE_SA_ADDR + 6'h01;
               plan_dest = ee_loader_pkg::DST_SA1;
            end
            default:
            begin
               plan_req.addr = ee_loader_pkg::EE_SA_ADDR + 6'h02;
               plan_dest = ee_loader_pkg::DST_SA2;
               plan_last = 1'b1;
            end
         endcase
      end
      else if (!store_r)
      begin
         plan_req.op = ee_loader_pkg::OP_READ;
         plan_req.addr = ptr_r[5:0];
         plan_dest = ee_loader_pkg::DST_GP;
         plan_last = 1'b1;
      end
      else if (step_r == 3'h0)
      begin
         plan_req.op = ee_loader_pkg::OP_EWEN;
         plan_req.addr = ee_loader_pkg::EWEN_ADDR;
      end
      else
      begin
         plan_req.op = ee_loader_pkg::OP_WRITE;
         plan_req.wait_rdy = 1'b1;
         if (tgt_r)
         begin
            plan_req.addr = ptr_r[5:0];
            plan_req.wdata = gp_r;
            plan_last = 1'b1;
         end
         else if (step_r == 3'h1)
         begin
            plan_req.addr = slot_addr;
            plan_req.wdata = cfg_word_o;
         end
         else
         begin
            plan_req.addr = slot_addr + 6'h01;
            plan_req.wdata = base_word_o;
            plan_last = 1'b1;
         end
      end
   end

   // Operation sequencer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= M_BOOT;
         boot_cnt_r <= 2'h0;
         present_r <= 1'b0;
         slot_r <= ee_loader_pkg::SLOT_DEFAULT;
         tgt_r <= 1'b0;
         store_r <= 1'b0;
         step_r <= 3'h0;
         start_r <= 1'b0;
      end
      else
      begin
         start_r <= 1'b0;
         case (state_r)
            M_BOOT:
            begin
               boot_cnt_r <= boot_cnt_r + 2'h1;
               if (boot_cnt_r == 2'(ee_loader_pkg::BOOT_SETTLE_CYC - 1))
               begin
                  present_r <= pres_s2_r;
                  slot_r <= slot_s2_r;
                  tgt_r <= 1'b0;
                  store_r <= 1'b0;
                  step_r <= (slot_s2_r == ee_loader_pkg::SLOT_DEFAULT) ? 3'h2 : 3'h0;
                  state_r <= pres_s2_r ? M_ISSUE : M_IDLE;
               end
            end
            M_IDLE:
            begin
               if (ctrl_wr)
                  tgt_r <= dat_i[ee_loader_pkg::CTRL_SEL_BIT];
               if (ctrl_wr && present_r &&
                   (dat_i[ee_loader_pkg::CTRL_FETCH_BIT] || dat_i[ee_loader_pkg::CTRL_STORE_BIT]))
               begin
                  slot_r <= slot_s2_r;
                  store_r <= ~dat_i[ee_loader_pkg::CTRL_FETCH_BIT];
                  if (dat_i[ee_loader_pkg::CTRL_FETCH_BIT] && !dat_i[ee_loader_pkg::CTRL_SEL_BIT]
                      && slot_s2_r == ee_loader_pkg::SLOT_DEFAULT)
                     step_r <= 3'h2;
                  else
                     step_r <= 3'h0;
                  state_r <= M_ISSUE;
               end
            end
            M_ISSUE:
            begin
               start_r <= 1'b1;
               state_r <= M_WAIT;
            end
            M_WAIT:
            begin
               if (xfer_done)
               begin
                  if (plan_last)
                     state_r <= M_IDLE;
                  else
                  begin
                     step_r <= step_r + 3'h1;
                     state_r <= M_ISSUE;
                  end
               end
            end
            default:
               state_r <= M_IDLE;
         endcase
      end
   end

   // Setup registers: EEPROM results and software writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_word_o <= CFG_DEFAULT;
         base_word_o <= BASE_DEFAULT;
         sa0_r <= SA_DEFAULT[15:0];
         sa1_r <= SA_DEFAULT[31:16];
         sa2_r <= SA_DEFAULT[47:32];
         gp_r <= ee_loader_pkg::GP_RST;
         ptr_r <= ee_loader_pkg::PTR_RST;
      end
      else if (state_r == M_WAIT && xfer_done)
      begin
         case (plan_dest)
            ee_loader_pkg::DST_CFG: cfg_word_o <= xfer_rdata;
            ee_loader_pkg::DST_BASE: base_word_o <= xfer_rdata;
            ee_loader_pkg::DST_SA0: sa0_r <= xfer_rdata;
            ee_loader_pkg::DST_SA1: sa1_r <= xfer_rdata;
            ee_loader_pkg::DST_SA2: sa2_r <= xfer_rdata;
            ee_loader_pkg::DST_GP: gp_r <= xfer_rdata;
            default: gp_r <= gp_r;
         endcase
      end
      else if (wr_go && !busy)
      begin
         if (adr_i == ee_loader_pkg::OFS_PTR)
            ptr_r <= merge16(ptr_r, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_GP)
            gp_r <= merge16(gp_r, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_CFG)
            cfg_word_o <= merge16(cfg_word_o, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_BASE)
            base_word_o <= merge16(base_word_o, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_SA0)
            sa0_r <= merge16(sa0_r, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_SA1)
            sa1_r <= merge16(sa1_r, dat_i, sel_i);
         else if (adr_i == ee_loader_pkg::OFS_SA2)
            sa2_r <= merge16(sa2_r, dat_i, sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         station_addr_words_o <= SA_DEFAULT;
      else
         station_addr_words_o <= {sa2_r, sa1_r, sa0_r};
   end

   // Read data decode
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (adr_i == ee_loader_pkg::OFS_CTRL)
      begin
         rd_mux[ee_loader_pkg::CTRL_SEL_BIT] = tgt_r;
         rd_mux[ee_loader_pkg::CTRL_FETCH_BIT] = busy;
         rd_mux[ee_loader_pkg::CTRL_STORE_BIT] = busy;
      end
      else if (busy)
         rd_mux = 32'h00000000;
      else if (adr_i == ee_loader_pkg::OFS_PTR)
         rd_mux[15:0] = ptr_r;
      else if (adr_i == ee_loader_pkg::OFS_GP)
         rd_mux[15:0] = gp_r;
      else if (adr_i == ee_loader_pkg::OFS_CFG)
         rd_mux[15:0] = cfg_word_o;
      else if (adr_i == ee_loader_pkg::OFS_BASE)
         rd_mux[15:0] = base_word_o;
      else if (adr_i == ee_loader_pkg::OFS_SA0)
         rd_mux[15:0] = sa0_r;
      else if (adr_i == ee_loader_pkg::OFS_SA1)
         rd_mux[15:0] = sa1_r;
      else if (adr_i == ee_loader_pkg::OFS_SA2)
         rd_mux[15:0] = sa2_r;
   end

   // Wishbone answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end
      else
      begin
         ack_o <= acc & ~ack_o;
         if (acc && !ack_o)
            dat_o <= rd_mux;
      end
   end

   ee_word_xfer #(
      .WR_TIMEOUT_CYC(WR_TIMEOUT_CYC)
   ) u_xfer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start_r),
      .req_i(plan_req),
      .eeprom_do_i(eeprom_do_i),
      .eeprom_cs_o(eeprom_cs_o),
      .eeprom_sk_o(eeprom_sk_o),
      .eeprom_di_o(eeprom_di_o),
      .rdata_o(xfer_rdata),
      .done_o(xfer_done)
   );
endmodule : serial_eeprom_setup_loader

//--- bench/loader_monitor.sv
// Checker for the setup loader: bus handshake, busy read-back, serial framing.
// Bound to the loader top; sees its ports only, one clock domain.
`timescale 1ns/1ps
module loader_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic eeprom_present_pin_i,
   input wire logic eeprom_cs_o,
   input wire logic eeprom_sk_o,
   input wire logic eeprom_di_o
);
   logic sk_q;
   logic [5:0] half_r;
   logic [4:0] clks_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Length of the current serial clock level
   always_ff @(posedge clk_i)
   begin
      sk_q <= eeprom_sk_o;
      half_r <= (eeprom_sk_o != sk_q) ? 6'h01 : half_r + 6'h01;
   end
   // Serial clocks within one chip select frame
   always_ff @(posedge clk_i)
   begin
      if (!eeprom_cs_o)
         clks_r <= 5'h00;
      else if (eeprom_sk_o && !sk_q)
         clks_r <= clks_r + 5'h01;
   end
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence ctrl_rd_s;
      ack_o && !we_i && adr_i == ee_loader_pkg::OFS_CTRL;
   endsequence
   ack_timing_a: assert property (req_s |=> ack_o) else $error("ack late");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
   busy_bits_a: assert property (ctrl_rd_s ##0 (eeprom_cs_o && $past(eeprom_cs_o))
      |-> dat_o[2:1] == 2'h3) else $error("busy bits low");
   blocked_read_a: assert property (ack_o && !we_i && adr_i != ee_loader_pkg::OFS_CTRL
      && eeprom_cs_o && $past(eeprom_cs_o) |-> dat_o == 32'h0) else $error("busy read");
   absent_bits_a: assert property (ctrl_rd_s ##0 !eeprom_present_pin_i
      |-> dat_o[2:1] == 2'h0) else $error("request bits set");
   no_access_a: assert property (!eeprom_present_pin_i |-> !eeprom_cs_o) else $error("cs");
   boot_fetch_a: assert property ($fell(rst_i) && eeprom_present_pin_i
      |-> ##[1:30] eeprom_cs_o) else $error("no boot fetch");
   sk_frame_a: assert property (eeprom_sk_o |-> eeprom_cs_o) else $error("sk outside cs");
   sk_half_a: assert property ($fell(eeprom_sk_o) |-> half_r == 6'h14) else $error("sk");
   di_steady_a: assert property (eeprom_sk_o && $past(eeprom_sk_o)
      |-> $stable(eeprom_di_o)) else $error("di moved");
   frame_len_a: assert property ($fell(eeprom_cs_o)
      |-> clks_r == 5'h00 || clks_r == 5'h09 || clks_r == 5'h19) else $error("frame");
endmodule : loader_monitor
bind serial_eeprom_setup_loader loader_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
   .eeprom_present_pin_i(eeprom_present_pin_i), .eeprom_cs_o(eeprom_cs_o),
   .eeprom_sk_o(eeprom_sk_o), .eeprom_di_o(eeprom_di_o));

//--- bench/ee_serial_model.sv
// Behavioural 64x16 three-wire serial EEPROM.
// Driven by the loader's chip select, serial clock and data in.
`timescale 1ns/1ps
module ee_serial_model #(
   parameter int BUSY_NS = 900
) (
   input wire logic cs_i,
   input wire logic sk_i,
   input wire logic di_i,
   output logic do_o
);
   logic [15:0] mem [64];
   logic [8:0] head_r = 9'h000;
   logic [15:0] wd_r = 16'h0000;
   logic [4:0] cnt_r = 5'h00;
   logic wen_r = 1'b0;
   logic do_r = 1'b0;
   // Released line shows the inverse of its last level
   assign do_o = cs_i ? do_r : ~do_r;
   always @(posedge cs_i)
   begin
      cnt_r = 5'h00;
      head_r = 9'h000;
   end
   always @(posedge sk_i)
   begin
      if (cs_i)
      begin
         if (cnt_r < 5'h09)
            head_r = {head_r[7:0], di_i};
         else if (head_r[8:6] == 3'h6)
            do_r = mem[head_r[5:0]][5'h18 - cnt_r];
         else
            wd_r = {wd_r[14:0], di_i};
         if (cnt_r == 5'h08 && head_r[8:6] == 3'h4)
            wen_r = head_r[5:4] == 2'h3;
         if (cnt_r == 5'h08 && head_r[8:6] == 3'h6)
            do_r = 1'b0;
         cnt_r = cnt_r + 5'h01;
      end
   end
   // Write lands only when enabled, then ready goes low for a while
   always @(negedge cs_i)
   begin
      if (cnt_r == 5'h19 && head_r[8:6] == 3'h5 && wen_r)
      begin
         mem[head_r[5:0]] = wd_r;
         do_r = 1'b0;
         #(BUSY_NS) do_r = 1'b1;
      end
   end
endmodule : ee_serial_model

//--- bench/test_serial_eeprom_setup_loader.sv
// Bench for the setup loader: boot fetch, slot 7 fetch, store, word access
// and absent EEPROM. A behavioural serial EEPROM answers the link.
`timescale 1ns/1ps
module test_serial_eeprom_setup_loader;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req = 1'b0;
   logic we_i = 1'b0;
   logic present_i = 1'b1;
   logic [2:0] slot_i = 3'h2;
   logic [3:0] sel_i = 4'h3;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd;
   logic ack_o, ee_do, ee_cs, ee_sk, ee_di;
   logic [15:0] cfg_w, base_w;
   logic [47:0] sta_w;
   int err_total = 0;
   int checks_done = 0;
   int cyc_n = 0;
   serial_eeprom_setup_loader #(.WR_TIMEOUT_CYC(50)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
      .we_i(we_i), .cyc_i(req), .stb_i(req), .dat_o(dat_o), .ack_o(ack_o),
      .board_slot_select_pins_i(slot_i), .eeprom_present_pin_i(present_i),
      .eeprom_do_i(ee_do), .eeprom_cs_o(ee_cs), .eeprom_sk_o(ee_sk), .eeprom_di_o(ee_di),
      .cfg_word_o(cfg_w), .base_word_o(base_w), .station_addr_words_o(sta_w));
   ee_serial_model ee_u (.cs_i(ee_cs), .sk_i(ee_sk), .di_i(ee_di), .do_o(ee_do));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000)
      begin
         err_total++;
         conclude();
      end
   end
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      req <= 1'b1;
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1);
      rd = dat_o;
      req <= 1'b0;
   endtask : wb
   task automatic poll();
      do
         wb(ee_loader_pkg::OFS_CTRL, 1'b0, 32'h0);
      while (rd[2:1] !== 2'h0);
   endtask : poll
   task automatic boot(input logic p, input logic [2:0] s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      present_i <= p;
      slot_i <= s;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : boot
   task automatic t_boot();
      ee_u.mem[8] = 16'h1234;
      ee_u.mem[9] = 16'h5678;
      ee_u.mem[32] = 16'h0a0b;
      ee_u.mem[33] = 16'h0c0d;
      ee_u.mem[34] = 16'h0e0f;
      boot(1'b1, 3'h2);
      wait (ee_cs === 1'b1);
      wb(ee_loader_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(rd, 48'h6);
      wb(ee_loader_pkg::OFS_PTR, 1'b1, 32'h15);
      wb(ee_loader_pkg::OFS_PTR, 1'b0, 32'h0);
      check(rd, 48'h0);
      poll();
      check(cfg_w, 48'h1234);
      check(base_w, 48'h5678);
      check(sta_w, 48'h0e0f_0c0d_0a0b);
      wb(ee_loader_pkg::OFS_PTR, 1'b0, 32'h0);
      check(rd, 48'h0);
   endtask : t_boot
   task automatic t_slot7();
      ee_u.mem[32] = 16'h1111;
      ee_u.mem[33] = 16'h2222;
      ee_u.mem[34] = 16'h3333;
      slot_i <= 3'h7;
      repeat (4) @(posedge clk_i);
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h2);
      poll();
      check(cfg_w, 48'h1234);
      check(sta_w, 48'h3333_2222_1111);
   endtask : t_slot7
   task automatic t_store();
      slot_i <= 3'h5;
      repeat (4) @(posedge clk_i);
      wb(ee_loader_pkg::OFS_CFG, 1'b1, 32'h00c3);
      wb(ee_loader_pkg::OFS_BASE, 1'b1, 32'h0300);
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h4);
      wb(ee_loader_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(rd, 48'h6);
      poll();
      check(rd, 48'h0);
      check(ee_u.mem[20], 48'h00c3);
      check(ee_u.mem[21], 48'h0300);
   endtask : t_store
   task automatic t_gp();
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h1);
      wb(ee_loader_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(rd, 48'h1);
      wb(ee_loader_pkg::OFS_PTR, 1'b1, 32'hffbf);
      wb(ee_loader_pkg::OFS_GP, 1'b1, 32'ha55a);
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h5);
      poll();
      check(rd, 48'h1);
      check(ee_u.mem[63], 48'ha55a);
      ee_u.mem[42] = 16'h3c96;
      wb(ee_loader_pkg::OFS_PTR, 1'b1, 32'h002a);
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h3);
      poll();
      wb(ee_loader_pkg::OFS_GP, 1'b0, 32'h0);
      check(rd, 48'h3c96);
      check(cfg_w, 48'h00c3);
   endtask : t_gp
   task automatic t_absent();
      boot(1'b0, 3'h1);
      wb(ee_loader_pkg::OFS_CTRL, 1'b1, 32'h2);
      wb(ee_loader_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(rd, 48'h0);
      check(sta_w, 48'h0);
      wb(ee_loader_pkg::OFS_CFG, 1'b1, 32'h0042);
      wb(ee_loader_pkg::OFS_CFG, 1'b0, 32'h0);
      check(rd, 48'h0042);
      sel_i <= 4'h2;
      wb(ee_loader_pkg::OFS_CFG, 1'b1, 32'hab99);
      sel_i <= 4'h3;
      wb(ee_loader_pkg::OFS_CFG, 1'b0, 32'h0);
      check(rd, 48'hab42);
      wb(8'h40, 1'b0, 32'h0);
      check(rd, 48'h0);
   endtask : t_absent
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial
   begin
      t_boot();
      t_slot7();
      t_store();
      t_gp();
      t_absent();
      conclude();
   end
endmodule : test_serial_eeprom_setup_loader
